// >>> logic/pemc_host.sv
// Behaviour
// - read needs chip enable and gate low
// - 100 us pulses, ten maximum, verify each
// - program needs supply, high gate, enable low
// - address and data stable, then enable pulse
// - verify reads back with gate and enable low
// - unpulsed devices stay unprogrammed, enable high
// - identity: line nine high, enable, gate low
`default_nettype none
module pemc_host #(
  parameter int PULSE_CYCLES_P = pemc_pkg::PULSE_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire pemc_pkg::pemc_cmd_s cmd,
  output logic cmd_ready,
  output logic rsp_valid,
  output pemc_pkg::pemc_rsp_s rsp,
  output pemc_pkg::pemc_pins_s pins,
  input wire logic [pemc_pkg::DATA_W-1:0] byte_data_in
);
  import pemc_pkg::*;

  typedef struct packed {
    pemc_state_e st;
    pemc_op_e op;
    logic [DATA_W-1:0] want;
    logic retry;
    logic ready;
    logic rsp_valid;
    pemc_rsp_s rsp;
    pemc_pins_s pins;
  } pemc_host_s;

  localparam pemc_pins_s PINS_RESET = '{
    byte_address_lines: '0,
    byte_data_out: ERASED_BYTE,
    byte_data_oe: 1'b0,
    chip_enable_b: 1'b1,
    output_gate_b: 1'b1,
    high_programming_level: 1'b0,
    vcc_program_level: 1'b0,
    identity_entry_line: 1'b0
  };

  localparam logic [TIMER_W-1:0] T_SETUP = TIMER_W'(SETUP_CYCLES);
  localparam logic [TIMER_W-1:0] T_PULSE = TIMER_W'(PULSE_CYCLES_P);
  localparam logic [TIMER_W-1:0] T_ACCESS = TIMER_W'(CS_ACCESS_CYCLES);
  localparam logic [TIMER_W-1:0] T_FLOAT = TIMER_W'(FLOAT_CYCLES);

  pemc_host_s s;
  pemc_host_s next_s;
  logic t_load;
  logic [TIMER_W-1:0] t_value;
  logic t_expired;
  logic match;

  // ****************************************
  // shared phase timer
  // ****************************************
  pemc_timer u_timer (
    .clock(clock),
    .rst_b(rst_b),
    .load(t_load),
    .value(t_value),
    .expired(t_expired)
  );

  // a program pass succeeds only if every cell now holds the wanted level
  assign match = (byte_data_in == s.want);

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    next_s = s;
    t_load = 1'b0;
    t_value = '0;
    next_s.rsp_valid = 1'b0;
    unique case (s.st)
      PEMC_IDLE: begin
        // chip enable stays high here: standby, and no other device is hit
        next_s.pins.chip_enable_b = 1'b1;
        if (cmd_valid && s.ready) begin
          next_s.ready = 1'b0;
          next_s.op = cmd.op;
          next_s.want = cmd.data;
          next_s.rsp.pulses = '0;
          next_s.pins.byte_address_lines = cmd.addr;
          t_load = 1'b1;
          if (cmd.op == PEMC_OP_PROGRAM) begin
            // device floats its outputs with the gate pin at the high level
            next_s.pins.byte_data_out = cmd.data;
            next_s.pins.byte_data_oe = 1'b1;
            next_s.pins.vcc_program_level = 1'b1;
            next_s.pins.high_programming_level = 1'b1;
            t_value = T_SETUP;
            next_s.st = PEMC_SETUP;
          end else begin
            if (cmd.op == PEMC_OP_IDENTIFY) begin
              next_s.pins.byte_address_lines = '0;
              next_s.pins.byte_address_lines[ID_SEL_BIT] = cmd.addr[ID_SEL_BIT];
              next_s.pins.identity_entry_line = 1'b1;
            end
            next_s.pins.output_gate_b = 1'b0;
            next_s.pins.chip_enable_b = 1'b0;
            t_value = T_ACCESS;
            next_s.st = PEMC_ACCESS;
          end
        end
      end
      PEMC_SETUP: begin
        // address, data and supply have been stable for the setup time
        if (t_expired) begin
          next_s.pins.chip_enable_b = 1'b0;
          next_s.rsp.pulses = s.rsp.pulses + 1'b1;
          t_load = 1'b1;
          t_value = T_PULSE;
          next_s.st = PEMC_PULSE;
        end
      end
      PEMC_PULSE: begin
        if (t_expired) begin
          next_s.pins.chip_enable_b = 1'b1;
          t_load = 1'b1;
          t_value = T_SETUP;
          next_s.st = PEMC_HOLD;
        end
      end
      PEMC_HOLD: begin
        // data hold done: drop the high level before reading back
        if (t_expired) begin
          next_s.pins.byte_data_oe = 1'b0;
          next_s.pins.high_programming_level = 1'b0;
          t_load = 1'b1;
          t_value = T_SETUP;
          next_s.st = PEMC_RECOVER;
        end
      end
      PEMC_RECOVER: begin
        if (t_expired) begin
          next_s.pins.output_gate_b = 1'b0;
          next_s.pins.chip_enable_b = 1'b0;
          t_load = 1'b1;
          t_value = T_ACCESS;
          next_s.st = PEMC_ACCESS;
        end
      end
      PEMC_ACCESS: begin
        // sample only once the access delay from chip enable has run
        if (t_expired) begin
          next_s.pins.output_gate_b = 1'b1;
          next_s.pins.chip_enable_b = 1'b1;
          next_s.rsp.data = byte_data_in;
          next_s.retry = 1'b0;
          t_load = 1'b1;
          t_value = T_FLOAT;
          next_s.st = PEMC_FLOAT;
          if (s.op == PEMC_OP_PROGRAM && !match && s.rsp.pulses < MAX_PULSES) begin
            next_s.retry = 1'b1;
          end else begin
            next_s.rsp.pass = (s.op == PEMC_OP_READ || s.op == PEMC_OP_IDENTIFY) || match;
            next_s.rsp_valid = 1'b1;
            next_s.pins.vcc_program_level = 1'b0;
            next_s.pins.identity_entry_line = 1'b0;
          end
        end
      end
      PEMC_FLOAT: begin
        // wait out the device float delay before driving data again
        if (t_expired) begin
          if (s.retry) begin
            next_s.pins.byte_data_oe = 1'b1;
            next_s.pins.high_programming_level = 1'b1;
            t_load = 1'b1;
            t_value = T_SETUP;
            next_s.st = PEMC_SETUP;
          end else begin
            next_s.ready = 1'b1;
            next_s.st = PEMC_IDLE;
          end
        end
      end
      default: begin
        next_s.st = PEMC_IDLE;
        next_s.ready = 1'b1;
        next_s.pins = PINS_RESET;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s.st <= PEMC_IDLE;
      s.op <= PEMC_OP_READ;
      s.want <= ERASED_BYTE;
      s.retry <= 1'b0;
      s.ready <= 1'b1;
      s.rsp_valid <= 1'b0;
      s.rsp <= '0;
      s.pins <= PINS_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // outputs straight from flops
  // ****************************************
  assign cmd_ready = s.ready;
  assign rsp_valid = s.rsp_valid;
  assign rsp = s.rsp;
  assign pins = s.pins;
endmodule
`default_nettype wire

// >>> logic/pemc_pkg.sv
`default_nettype none
package pemc_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLOCK_MHZ = 100;
  localparam int PULSE_US = 100;
  localparam int PULSE_CYCLES = PULSE_US * CLOCK_MHZ;
  localparam int SETUP_US = 2;
  localparam int SETUP_CYCLES = SETUP_US * CLOCK_MHZ;
  // chip_select_access_delay: no figure given, plain default
  localparam int CS_ACCESS_NS = 200;
  localparam int CS_ACCESS_CYCLES = (CS_ACCESS_NS * CLOCK_MHZ + 999) / 1000;
  localparam int FLOAT_NS = 130;
  localparam int FLOAT_CYCLES = (FLOAT_NS * CLOCK_MHZ + 999) / 1000;
  localparam logic [3:0] MAX_PULSES = 4'hA;
  localparam int TIMER_W = 14;

  // ****************************************
  // pin widths and resets
  // ****************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int ID_SEL_BIT = 0;
  localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    PEMC_OP_READ = 2'b00,
    PEMC_OP_PROGRAM = 2'b01,
    PEMC_OP_VERIFY = 2'b10,
    PEMC_OP_IDENTIFY = 2'b11
  } pemc_op_e;

  typedef enum logic [2:0] {
    PEMC_IDLE = 3'b000,
    PEMC_SETUP = 3'b001,
    PEMC_PULSE = 3'b010,
    PEMC_HOLD = 3'b011,
    PEMC_RECOVER = 3'b100,
    PEMC_ACCESS = 3'b101,
    PEMC_FLOAT = 3'b110
  } pemc_state_e;

  typedef struct packed {
    pemc_op_e op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pemc_cmd_s;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic pass;
    logic [3:0] pulses;
  } pemc_rsp_s;

  typedef struct packed {
    logic [ADDR_W-1:0] byte_address_lines;
    logic [DATA_W-1:0] byte_data_out;
    logic byte_data_oe;
    logic chip_enable_b;
    logic output_gate_b;
    logic high_programming_level;
    logic vcc_program_level;
    logic identity_entry_line;
  } pemc_pins_s;

  typedef struct packed {
    logic [TIMER_W-1:0] count;
  } pemc_timer_s;

endpackage
`default_nettype wire

// >>> logic/pemc_timer.sv
`default_nettype none
module pemc_timer (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [pemc_pkg::TIMER_W-1:0] value,
  output logic expired
);
  import pemc_pkg::*;

  pemc_timer_s s;
  pemc_timer_s next_s;

  // ****************************************
  // down counter, stops at zero
  // ****************************************
  always_comb begin
    next_s = s;
    if (load) begin
      next_s.count = value;
    end else if (s.count != '0) begin
      next_s.count = s.count - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // flop-based, so no loop through the caller's next-state logic
  assign expired = (s.count == '0);
endmodule
`default_nettype wire

// >>> sim/pemc_host_props.sv
`default_nettype none
module pemc_host_props #(
  parameter int PULSE_CYCLES_P = 20
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire pemc_pkg::pemc_cmd_s cmd,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire pemc_pkg::pemc_rsp_s rsp,
  input wire pemc_pkg::pemc_pins_s pins,
  input wire logic [pemc_pkg::DATA_W-1:0] byte_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import pemc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic [15:0] low_cnt;
  // count pulse length, too long for a repetition
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt <= '0;
    end else begin
      low_cnt <= (!pins.chip_enable_b && pins.high_programming_level) ? low_cnt + 16'h0001 : '0;
    end
  end
  a_pulse_width: assert property ($rose(pins.chip_enable_b) && pins.high_programming_level
    |-> low_cnt == 16'(PULSE_CYCLES_P + 1)) else $error("pulse width wrong");
  a_pulse_limit: assert property (rsp_valid |-> rsp.pulses <= MAX_PULSES)
    else $error("too many pulses");
  a_prog_supply: assert property (pins.high_programming_level |-> pins.vcc_program_level)
    else $error("programming level without supply");
  a_idle_standby: assert property (cmd_ready |-> pins.chip_enable_b
    && !pins.high_programming_level) else $error("idle not in standby");
  a_no_contention: assert property (!pins.output_gate_b |-> !pins.byte_data_oe)
    else $error("host drives while device gated");
  a_pulse_stable: assert property (!pins.chip_enable_b && pins.high_programming_level
    |-> $stable(pins.byte_address_lines) && $stable(pins.byte_data_out) && pins.byte_data_oe)
    else $error("address or data moved in pulse");
  a_id_clean: assert property (pins.identity_entry_line |-> !pins.high_programming_level)
    else $error("identity with programming level");
  a_access_wait: assert property ($fell(pins.chip_enable_b) && !pins.high_programming_level
    |=> !pins.chip_enable_b [*8]) else $error("access cut short");
  a_release_done: assert property (rsp_valid |-> pins.chip_enable_b && pins.output_gate_b)
    else $error("pins not released at answer");
endmodule
bind pemc_host pemc_host_props #(.PULSE_CYCLES_P(PULSE_CYCLES_P)) u_props (.clock(clock),
  .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
  .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .byte_data_in(byte_data_in));
`default_nettype wire

// >>> sim/pemc_eprom_model.sv
`default_nettype none
module pemc_eprom_model #(
  parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
  parameter logic [7:0] TYPE_CODE = 8'hA5, // arbitrary value
  parameter int NEED = 3
) (
  input wire pemc_pkg::pemc_pins_s pins,
  output logic [pemc_pkg::DATA_W-1:0] byte_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import pemc_pkg::*;
  logic [7:0] mem [int];
  int hits [int];
  logic [7:0] held = 8'h00;
  logic [7:0] dv;
  logic valid = 1'b0;
  logic drive;
  function automatic logic [7:0] rd(int a);
    return mem.exists(a) ? mem[a] : ERASED_BYTE;
  endfunction
  // slow cells: a byte takes NEED pulses, zeros only
  always @(negedge pins.chip_enable_b) begin
    if (pins.high_programming_level && pins.vcc_program_level) begin
      hits[pins.byte_address_lines] = hits.exists(pins.byte_address_lines) ?
        hits[pins.byte_address_lines] + 1 : 1;
      if (hits[pins.byte_address_lines] >= NEED) begin
        mem[pins.byte_address_lines] = rd(pins.byte_address_lines) & pins.byte_data_out;
      end
    end
  end
  // data not valid until access delay after a change of enable, gate, address or identity line
  always begin
    @(pins.chip_enable_b or pins.output_gate_b or pins.byte_address_lines or pins.identity_entry_line);
    valid = 1'b0;
    #150;
    valid = 1'b1;
  end
  assign drive = !pins.chip_enable_b && !pins.output_gate_b && !pins.high_programming_level && valid;
  assign dv = pins.identity_entry_line ? (pins.byte_address_lines[ID_SEL_BIT] ? TYPE_CODE : MAKER_CODE) : rd(pins.byte_address_lines);
  always @(dv or drive) begin
    if (drive) begin
      held = dv;
    end
  end
  // released lines show the inverse, never a stale byte
  assign byte_data_in = drive ? dv : pins.byte_data_oe ? pins.byte_data_out : ~held;
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; $display("BAD %0t mismatch", $time); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pemc_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0;
  pemc_cmd_s cmd = '0;
  logic cmd_ready;
  logic rsp_valid;
  pemc_rsp_s rsp;
  pemc_pins_s pins;
  logic [7:0] byte_data_in;
  int error_cnt = 0;
  int comparisons = 0;
  pemc_rsp_s r;
  always #5 clock = ~clock;
  pemc_host #(.PULSE_CYCLES_P(20)) DUT (.clock(clock), .rst_b(rst_b), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins),
    .byte_data_in(byte_data_in));
  pemc_eprom_model u_dev (.pins(pins), .byte_data_in(byte_data_in));
  task report_and_stop;
    $display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one command, bounded waits for take and answer
  task automatic xfer(input pemc_op_e op, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd = '{op, a, d};
    // the take wait is bounded too, so a stuck ready cannot hang the run
    while (cmd_ready !== 1'b1) begin
      @(posedge clock);
      #1;
      n++;
      if (n > 100) begin
        error_cnt++;
        $display("BAD %0t not taken", $time);
        report_and_stop();
      end
    end
    n = 0;
    @(posedge clock);
    #1;
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1) begin
      @(posedge clock);
      #1;
      n++;
      if (n > 8000) begin
        error_cnt++;
        $display("BAD %0t no answer", $time);
        report_and_stop();
      end
    end
    r = rsp;
  endtask
  task t_reset;
    `CHK(cmd_ready, 1'b1)
    `CHK(pins.chip_enable_b, 1'b1)
    `CHK(pins.byte_data_oe, 1'b0)
  endtask
  task t_identity;
    for (int i = 0; i < 2; i++) begin
      xfer(PEMC_OP_IDENTIFY, 16'(i), 8'h00);
      `CHK(r.data, i ? 8'hA5 : 8'h5A)
    end
  endtask
  task t_program;
    xfer(PEMC_OP_READ, 16'h1234, 8'h00);
    `CHK(r.data, 8'hFF)
    xfer(PEMC_OP_PROGRAM, 16'h1234, 8'h3C);
    `CHK({r.data, r.pass, r.pulses}, {8'h3C, 1'b1, 4'h3})
    xfer(PEMC_OP_VERIFY, 16'h1234, 8'h3C);
    `CHK(r.pass, 1'b1)
    xfer(PEMC_OP_VERIFY, 16'h1234, 8'h3D);
    `CHK(r.pass, 1'b0)
    xfer(PEMC_OP_READ, 16'h1235, 8'h00);
    `CHK(r.data, 8'hFF)
  endtask
  // raising bits cannot work: all ten pulses spent
  task t_no_raise;
    xfer(PEMC_OP_PROGRAM, 16'h1234, 8'hFF);
    `CHK({r.data, r.pass, r.pulses}, {8'h3C, 1'b0, 4'hA})
  endtask
  initial begin
    repeat (20) @(posedge clock);
    #1;
    t_reset();
    rst_b = 1'b1;
    t_identity();
    t_program();
    t_no_raise();
    report_and_stop();
  end
endmodule
`default_nettype wire
